// [hsitd_defs.svh]
// Offsets, field positions and codes of the interrupt transfer descriptor
`ifndef HSITD_DEFS_SVH
`define HSITD_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define HSITD_OFS_STAT 8'h20
`define HSITD_OFS_CLR 8'h24
`define HSITD_OFS_EN 8'h28
`define HSITD_RESP_OK 2'h0
`define HSITD_RESP_ERR 2'h2

// ----------------------------------------------------------------
// Descriptor fields, per 32-bit word
// ----------------------------------------------------------------
`define HSITD_F_V 0
`define HSITD_F_TOTAL 17:3
`define HSITD_F_MAXP 28:18
`define HSITD_F_MULT 30:29
`define HSITD_F_EPLO 31
`define HSITD_F_EPHI 2:0
`define HSITD_F_ADDR 9:3
`define HSITD_F_TOK 11:10
`define HSITD_F_TYPE 13:12
`define HSITD_F_SPLIT 14
`define HSITD_F_PERIOD 7:3
`define HSITD_F_BUF 23:8
`define HSITD_F_XFER 14:0
`define HSITD_F_CERR 24:23
`define HSITD_F_TOGGLE 25
`define HSITD_F_H 30
`define HSITD_F_A 31
`define HSITD_STAT_BASE 8

// ----------------------------------------------------------------
// Codes and event bits
// ----------------------------------------------------------------
`define HSITD_TYPE_INT 2'h3
`define HSITD_TOK_OUT 2'h0
`define HSITD_TOK_IN 2'h1
`define HSITD_EV_DONE 0
`define HSITD_EV_HALT 1
`define HSITD_EV_ERR 2

`endif

// [hsitd_pkg.sv]
// Types shared by the interrupt transfer descriptor logic
package hsitd_pkg;

  typedef enum logic [1:0] {HSITD_IDLE, HSITD_WAIT} hsitd_phase_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] ep;
    logic in_tok;
    logic split;
    logic toggle;
    logic [15:0] buf_addr;
    logic [14:0] offset;
    logic [10:0] len;
  } hsitd_txn_t;

  typedef struct packed {
    logic done;
    logic [10:0] bytes;
    logic err;
    logic babble;
    logic underrun;
    logic stall;
  } hsitd_res_t;

  typedef struct packed {
    logic [7:0][31:0] dw;
    hsitd_phase_t phase;
    hsitd_txn_t txn;
    logic req;
    logic [2:0] uf;
    logic [1:0] pkts;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic irq;
  } hsitd_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] raddr;
  } hsitd_axil_t;

endpackage : hsitd_pkg

// [hsitd_sched.sv]
// Millisecond polling decision for the interrupt descriptor
`timescale 1ns/10ps
module hsitd_sched (
  input wire logic [4:0] period_i,
  input wire logic [4:0] frame_i,
  output logic hit_o
);
  logic [4:0] span;

  // Period field zero means the microframe mask alone decides
  always_comb
  begin
    span = period_i | (period_i >> 1) | (period_i >> 2) | (period_i >> 3) | (period_i >> 4);
    hit_o = (period_i == 5'h0) || ((frame_i & span) == (period_i & span));
  end
endmodule : hsitd_sched

// [hsitd_axil.sv]
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/10ps
module hsitd_axil (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_go_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic rd_go_o,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  `include "hsitd_defs.svh"

  hsitd_pkg::hsitd_axil_t s, next_s;

  assign wr_go_o = !s.awready && !s.wready && !s.bvalid;
  assign rd_go_o = !s.arready && !s.rvalid;

  always_comb
  begin
    next_s = s;
    if (s.awready && awvalid_i)
    begin
      next_s.awready = 1'b0;
      next_s.waddr = awaddr_i;
    end
    if (s.wready && wvalid_i)
    begin
      next_s.wready = 1'b0;
      next_s.wdata = wdata_i;
      next_s.wstrb = wstrb_i;
    end
    if (wr_go_o)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok_i ? `HSITD_RESP_OK : `HSITD_RESP_ERR;
    end
    if (s.bvalid && bready_i)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.arready && arvalid_i)
    begin
      next_s.arready = 1'b0;
      next_s.raddr = araddr_i;
    end
    if (rd_go_o)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_ok_i ? rd_data_i : 32'h0;
      next_s.rresp = rd_ok_i ? `HSITD_RESP_OK : `HSITD_RESP_ERR;
    end
    if (s.rvalid && rready_i)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign awready_o = s.awready;
  assign wready_o = s.wready;
  assign bvalid_o = s.bvalid;
  assign bresp_o = s.bresp;
  assign arready_o = s.arready;
  assign rvalid_o = s.rvalid;
  assign rdata_o = s.rdata;
  assign rresp_o = s.rresp;
  assign wr_addr_o = s.waddr;
  assign wr_data_o = s.wdata;
  assign wr_strb_o = s.wstrb;
  assign rd_addr_o = s.raddr;
endmodule : hsitd_axil

// [hsitd_top.sv]
// Interrupt transfer descriptor engine with AXI4-Lite descriptor access
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module hsitd_top (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SOF_I,
  input wire logic [4:0] FRAME_I,
  input wire logic [2:0] UFRAME_I,
  output logic TXN_REQ_O,
  output hsitd_pkg::hsitd_txn_t TXN_O,
  input wire hsitd_pkg::hsitd_res_t RES_I,
  output logic IRQ_O
);
  `include "hsitd_defs.svh"

  hsitd_pkg::hsitd_state_t s, next_s;
  logic wr_go, wr_ok, rd_go, rd_ok, poll_hit;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  function automatic logic [31:0] hsitd_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction : hsitd_merge

  function automatic logic [10:0] hsitd_len(input logic [14:0] rem, input logic [10:0] maxp);
    return (rem < 15'(maxp)) ? rem[10:0] : maxp;
  endfunction : hsitd_len

  // ----------------------------------------------------------------
  // Bus slave and polling schedule
  // ----------------------------------------------------------------
  hsitd_axil u_axil (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .awaddr_i(S_AXI_AWADDR_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .bresp_o(S_AXI_BRESP_O),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .araddr_i(S_AXI_ARADDR_I),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .wr_go_o(wr_go),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_go_o(rd_go),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  hsitd_sched u_sched (
    .period_i(s.dw[2][`HSITD_F_PERIOD]),
    .frame_i(FRAME_I),
    .hit_o(poll_hit)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_ok = (wr_addr < `HSITD_OFS_STAT) || (wr_addr == `HSITD_OFS_CLR) ||
            (wr_addr == `HSITD_OFS_EN);
    rd_ok = (rd_addr < `HSITD_OFS_STAT) || (rd_addr == `HSITD_OFS_STAT) ||
            (rd_addr == `HSITD_OFS_CLR) || (rd_addr == `HSITD_OFS_EN);
    rd_data = 32'h0;
    if (rd_addr < `HSITD_OFS_STAT)
      rd_data = s.dw[rd_addr[4:2]];
    else if (rd_addr == `HSITD_OFS_STAT)
      rd_data = 32'(s.irq_st);
    else if (rd_addr == `HSITD_OFS_EN)
      rd_data = 32'(s.irq_en);
  end

  // ----------------------------------------------------------------
  // Descriptor engine
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [14:0] total;
    logic [14:0] xfer;
    logic [14:0] rem;
    logic [14:0] got;
    logic [10:0] maxp;
    logic [1:0] cerr;
    logic [1:0] tok;
    logic [2:0] ev;
    logic runnable;
    logic fatal;
    logic fin;
    hsitd_pkg::hsitd_txn_t t;
    next_s = s;
    next_s.req = 1'b0;
    total = s.dw[0][`HSITD_F_TOTAL];
    maxp = s.dw[0][`HSITD_F_MAXP];
    xfer = s.dw[3][`HSITD_F_XFER];
    rem = total - xfer;
    got = 15'(RES_I.bytes);
    cerr = s.dw[3][`HSITD_F_CERR];
    tok = s.dw[1][`HSITD_F_TOK];
    ev = 3'h0;
    fin = 1'b0;
    // Only named fields are looked at; reserved bits never steer anything
    runnable = s.dw[0][`HSITD_F_V] && s.dw[3][`HSITD_F_A] && !s.dw[3][`HSITD_F_H] &&
               (s.dw[1][`HSITD_F_TYPE] == `HSITD_TYPE_INT) &&
               (tok == `HSITD_TOK_OUT || tok == `HSITD_TOK_IN) &&
               (s.dw[0][`HSITD_F_MULT] != 2'h0);
    // Babble, stall and the last allowed error end the descriptor for good
    fatal = RES_I.stall || RES_I.babble || (RES_I.err && cerr == 2'h1);
    t.addr = s.dw[1][`HSITD_F_ADDR];
    t.ep = {s.dw[1][`HSITD_F_EPHI], s.dw[0][`HSITD_F_EPLO]};
    t.in_tok = (tok == `HSITD_TOK_IN);
    t.split = s.dw[1][`HSITD_F_SPLIT];
    t.toggle = s.dw[3][`HSITD_F_TOGGLE];
    t.buf_addr = s.dw[2][`HSITD_F_BUF];
    t.offset = xfer;
    t.len = hsitd_len(rem, maxp);

    if (wr_go)
    begin
      if (wr_addr < `HSITD_OFS_STAT)
        next_s.dw[wr_addr[4:2]] = hsitd_merge(s.dw[wr_addr[4:2]], wr_data, wr_strb);
      else if (wr_addr == `HSITD_OFS_CLR)
        next_s.irq_st = s.irq_st & ~wr_data[2:0];
      else if (wr_addr == `HSITD_OFS_EN)
        next_s.irq_en = wr_data[2:0];
    end

    unique case (s.phase)
      hsitd_pkg::HSITD_IDLE:
      begin
        if (SOF_I && runnable && poll_hit && s.dw[4][UFRAME_I])
        begin
          next_s.uf = UFRAME_I;
          next_s.pkts = 2'h1;
          next_s.req = 1'b1;
          next_s.txn = t;
          next_s.phase = hsitd_pkg::HSITD_WAIT;
        end
      end
      hsitd_pkg::HSITD_WAIT:
      begin
        if (RES_I.done)
        begin
          next_s.dw[4][`HSITD_STAT_BASE + 3*s.uf +: 3] =
            {RES_I.underrun, RES_I.babble, RES_I.err};
          if (RES_I.err && cerr != 2'h0)
            next_s.dw[3][`HSITD_F_CERR] = cerr - 2'h1;
          if (fatal)
          begin
            next_s.dw[3][`HSITD_F_H] = 1'b1;
            next_s.dw[3][`HSITD_F_A] = 1'b0;
            next_s.dw[0][`HSITD_F_V] = 1'b0;
            ev[`HSITD_EV_HALT] = 1'b1;
            fin = 1'b1;
          end
          else if (RES_I.err || RES_I.underrun)
          begin
            // Retried only at a microframe whose mask bit is still set; this one's bit is cleared, toggle unchanged
            ev[`HSITD_EV_ERR] = 1'b1;
            fin = 1'b1;
          end
          else
          begin
            next_s.dw[3][`HSITD_F_TOGGLE] = ~s.dw[3][`HSITD_F_TOGGLE];
            next_s.dw[3][`HSITD_F_XFER] = xfer + got;
            if (got >= rem || RES_I.bytes < maxp)
            begin
              next_s.dw[0][`HSITD_F_V] = 1'b0;
              next_s.dw[3][`HSITD_F_A] = 1'b0;
              ev[`HSITD_EV_DONE] = 1'b1;
              fin = 1'b1;
            end
            else if (s.pkts < s.dw[0][`HSITD_F_MULT])
            begin
              next_s.pkts = s.pkts + 2'h1;
              next_s.req = 1'b1;
              next_s.txn.toggle = ~s.dw[3][`HSITD_F_TOGGLE];
              next_s.txn.offset = xfer + got;
              next_s.txn.len = hsitd_len(rem - got, maxp);
            end
            else
            begin
              fin = 1'b1;
            end
          end
          if (fin)
          begin
            next_s.dw[4][s.uf] = 1'b0;
            next_s.phase = hsitd_pkg::HSITD_IDLE;
          end
        end
      end
      default:
      begin
        next_s.phase = hsitd_pkg::HSITD_IDLE;
      end
    endcase

    // Set after clear, so an event in the clearing cycle survives
    next_s.irq_st = next_s.irq_st | ev;
    next_s.irq = |(next_s.irq_st & next_s.irq_en);
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      s <= '0;
    else
      s <= next_s;
  end

  assign TXN_REQ_O = s.req;
  assign TXN_O = s.txn;
  assign IRQ_O = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  logic clean_done;
  assign clean_done = s.phase == hsitd_pkg::HSITD_WAIT && RES_I.done && !RES_I.err &&
                      !RES_I.babble && !RES_I.underrun && !RES_I.stall;

  a_halt_sets_flag: assert property (
    s.phase == hsitd_pkg::HSITD_WAIT && RES_I.done &&
    (RES_I.stall || (RES_I.err && s.dw[3][`HSITD_F_CERR] == 2'h1))
    |=> s.dw[3][`HSITD_F_H] && !s.dw[0][`HSITD_F_V])
    else $error("halt flag not set after stall");
  a_toggle_written: assert property (
    clean_done |=> s.dw[3][`HSITD_F_TOGGLE] != $past(s.dw[3][`HSITD_F_TOGGLE]))
    else $error("toggle not advanced");
  a_count_adds: assert property (
    clean_done |=> s.dw[3][`HSITD_F_XFER] ==
      15'($past(s.dw[3][`HSITD_F_XFER]) + 15'($past(RES_I.bytes))))
    else $error("transferred count wrong");
  a_active_cleared: assert property (
    $fell(s.dw[0][`HSITD_F_V]) && $past(s.phase == hsitd_pkg::HSITD_WAIT && RES_I.done)
    |-> !s.dw[3][`HSITD_F_A])
    else $error("active left set");
  a_mask_cleared: assert property (
    s.phase == hsitd_pkg::HSITD_IDLE && $past(s.phase == hsitd_pkg::HSITD_WAIT) && !$past(wr_go)
    |-> !s.dw[4][$past(s.uf)])
    else $error("microframe mask bit not cleared");
  a_token_addr: assert property (
    TXN_REQ_O && $past(s.phase == hsitd_pkg::HSITD_IDLE)
    |-> TXN_O.addr == $past(s.dw[1][`HSITD_F_ADDR]))
    else $error("wrong function address");
  a_endpoint_num: assert property (
    TXN_REQ_O && $past(s.phase == hsitd_pkg::HSITD_IDLE)
    |-> TXN_O.ep == {$past(s.dw[1][`HSITD_F_EPHI]), $past(s.dw[0][`HSITD_F_EPLO])})
    else $error("wrong endpoint number");
  a_token_kind: assert property (
    TXN_REQ_O && $past(s.phase == hsitd_pkg::HSITD_IDLE)
    |-> $past(s.dw[1][`HSITD_F_TYPE]) == `HSITD_TYPE_INT &&
        TXN_O.in_tok == ($past(s.dw[1][`HSITD_F_TOK]) == `HSITD_TOK_IN))
    else $error("token issued for wrong type or pid");
  a_split_select: assert property (
    TXN_REQ_O && $past(s.phase == hsitd_pkg::HSITD_IDLE)
    |-> TXN_O.split == $past(s.dw[1][`HSITD_F_SPLIT]))
    else $error("split select not followed");
  a_packets_bound: assert property (
    TXN_REQ_O |-> s.pkts <= s.dw[0][`HSITD_F_MULT] ##1 !TXN_REQ_O)
    else $error("too many packets in one execution");

  c_issue: cover property (TXN_REQ_O);
  c_complete: cover property (clean_done ##1 !s.dw[0][`HSITD_F_V]);
  c_halted: cover property ($rose(s.dw[3][`HSITD_F_H]));
  c_second_packet: cover property (TXN_REQ_O && s.pkts == 2'h2);
endmodule : hsitd_top

// [hsitd_ep_model.sv]
// Far-side interrupt endpoint model answering descriptor transactions
`timescale 1ns/10ps
module hsitd_ep_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire hsitd_pkg::hsitd_txn_t txn_i,
  input wire logic [3:0] dly_i,
  input wire logic [3:0] flags_i,
  output hsitd_pkg::hsitd_res_t res_o
);
  logic [4:0] cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 5'h0;
      res_o <= '0;
    end
    else
    begin
      if (req_i)
        cnt <= {1'b0, dly_i} + 5'h1;
      else if (cnt != 5'h0)
        cnt <= cnt - 5'h1;
      if (!req_i && cnt == 5'h1)
        // Whole packet, even when a fault is reported
        res_o <= {1'b1, txn_i.len, flags_i};
      else
        // Outside the answer cycle the payload churns, so stale values never match
        res_o <= {1'b0, ~res_o.bytes, ~res_o[3:0]};
    end
  end
endmodule : hsitd_ep_model

// [hsitd_top_tb_top.sv]
// Self-checking bench for the interrupt transfer descriptor engine
`timescale 1ns/10ps
module hsitd_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, sof = 1'b0, awr, wr, bv, arr, rv, req, irq;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd, v;
  logic [1:0] br, rr, rsp;
  logic [4:0] frm = 5'h0;
  logic [2:0] ufr = 3'h0;
  logic [3:0] dly = 4'h0, flg = 4'h0;
  hsitd_pkg::hsitd_txn_t txn;
  hsitd_pkg::hsitd_res_t res;
  int miscompares = 0, checked = 0;

  hsitd_top i_hsitd_top (.MCLK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .SOF_I(sof), .FRAME_I(frm), .UFRAME_I(ufr), .TXN_REQ_O(req), .TXN_O(txn),
    .RES_I(res), .IRQ_O(irq));

  hsitd_ep_model i_hsitd_ep_model (.clk_i(clk), .rst_i(rst), .req_i(req), .txn_i(txn),
    .dly_i(dly), .flags_i(flg), .res_o(res));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic conclude();
  begin
    if (miscompares == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  end
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  end
  endtask : chk

  task automatic chkt(input hsitd_pkg::hsitd_txn_t e);
  begin
    checked++;
    if (txn !== e)
    begin
      miscompares++;
      $display("ERROR txn expected %h seen %h", e, txn);
    end
  end
  endtask : chkt

  task automatic tmo();
  begin
    chk("wait", 32'h0, 32'h1);
    conclude();
  end
  endtask : tmo

  // Write; bready stays high, which is legal with no response pending
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic aw_hs, w_hs, b_hs;
    logic [1:0] bsp;
  begin
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    bsp = 2'h0;
    for (n = 0; n < 40; n++)
    begin
      // Levels read mid-cycle are the ones the coming edge samples
      @(negedge clk);
      aw_hs = awr;
      w_hs = wr;
      b_hs = bv;
      bsp = br;
      @(posedge clk);
      if (aw_hs === 1'b1) awv <= 1'b0;
      if (w_hs === 1'b1) wv <= 1'b0;
      if (b_hs === 1'b1) break;
    end
    if (n == 40) tmo();
    else chk("bresp", {30'h0, e}, {30'h0, bsp});
  end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    logic ar_hs, r_hs;
  begin
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk);
      ar_hs = arr;
      r_hs = rv;
      v = rd;
      rsp = rr;
      @(posedge clk);
      if (ar_hs === 1'b1) arv <= 1'b0;
      if (r_hs === 1'b1) break;
    end
    if (n == 40) tmo();
  end
  endtask : axr

  task automatic rck(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
  begin
    axr(a);
    chk(n, e, v & m);
    chk("rresp", 32'h0, {30'h0, rsp});
  end
  endtask : rck

  task automatic chkirq(input logic e);
  begin
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk);
  end
  endtask : chkirq

  // Microframe start; waits for the endpoint answer when a poll is due
  task automatic sofp(input logic [4:0] f, input logic [2:0] u, input logic hit);
    int n;
  begin
    sof <= 1'b1;
    frm <= f;
    ufr <= u;
    @(posedge clk);
    sof <= 1'b0;
    @(negedge clk);
    chk("txn_req", {31'h0, hit}, {31'h0, req});
    for (n = 0; hit && n < 20; n++)
    begin
      if (res.done === 1'b1) break;
      @(negedge clk);
    end
    if (hit && n == 20) tmo();
    else @(posedge clk);
  end
  endtask : sofp

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rck("dw0_rst", 8'h00, 32'hffffffff, 32'h0);
    axr(8'h40);
    chk("unmapped", 32'h2, {30'h0, rsp});
    axw(8'h40, 32'h1, 2'h2);
    axw(8'h28, 32'h7, 2'h0);
    axw(8'h00, 32'ha0200041, 2'h0);
    axw(8'h04, 32'h001074ad, 2'h0);
    // Buffer start from a CPU address of 1400h
    axw(8'h08, ((32'h1400 - 32'h400) >> 3) << 8, 2'h0);
    axw(8'h0c, 32'h87800000, 2'h0);
    axw(8'h10, 32'h4, 2'h0);
    dly <= 4'h3;
    sofp(5'h0, 3'h1, 1'b0);
    sofp(5'h0, 3'h2, 1'b1);
    chkt({7'h15, 4'hb, 3'h7, 16'h0200, 15'h0, 11'h8});
    rck("dw0", 8'h00, 32'hffffffff, 32'ha0200040);
    rck("dw3", 8'h0c, 32'hc3ffffff, 32'h01800008);
    rck("dw4", 8'h10, 32'hffffffff, 32'h0);
    rck("stat", 8'h20, 32'h7, 32'h1);
    chkirq(1'b1);
    axw(8'h24, 32'h1, 2'h0);
    chkirq(1'b0);
    dly <= 4'h0;
    flg <= 4'h8;
    axw(8'h28, 32'h1, 2'h0);
    axw(8'h00, 32'ha0200041, 2'h0);
    axw(8'h04, 32'h000070ad, 2'h0);
    axw(8'h08, 32'h00020020, 2'h0);
    axw(8'h0c, 32'h80800000, 2'h0);
    axw(8'h10, 32'h20, 2'h0);
    sofp(5'h03, 3'h5, 1'b0);
    sofp(5'h0c, 3'h5, 1'b1);
    chkt({7'h15, 4'hb, 3'h2, 16'h0200, 15'h0, 11'h8});
    rck("halt", 8'h0c, 32'hc0000000, 32'h40000000);
    rck("valid", 8'h00, 32'h1, 32'h0);
    rck("uf5_res", 8'h10, 32'h03800000, 32'h00800000);
    rck("stat", 8'h20, 32'h2, 32'h2);
    chkirq(1'b0);
    axw(8'h28, 32'h2, 2'h0);
    chkirq(1'b1);
    axw(8'h24, 32'h2, 2'h0);
    chkirq(1'b0);
    // Retryable error: count drops, descriptor stays live
    axw(8'h0c, 32'h81000000, 2'h0);
    axw(8'h00, 32'ha0200041, 2'h0);
    axw(8'h08, 32'h00020000, 2'h0);
    axw(8'h10, 32'h1, 2'h0);
    sofp(5'h07, 3'h0, 1'b1);
    rck("cerr", 8'h0c, 32'hc1800000, 32'h80800000);
    rck("uf0_res", 8'h10, 32'h00000701, 32'h00000100);
    rck("live", 8'h00, 32'h1, 32'h1);
    axw(8'h20, 32'h0, 2'h2);
    rck("stat", 8'h20, 32'h4, 32'h4);
    // Two packets in one execution, count kept between them
    flg <= 4'h0;
    axw(8'h00, 32'hc0200081, 2'h0);
    axw(8'h0c, 32'h80000000, 2'h0);
    axw(8'h10, 32'h8, 2'h0);
    sofp(5'h01, 3'h3, 1'b1);
    repeat (4) @(posedge clk);
    chkt({7'h15, 4'hb, 3'h3, 16'h0200, 15'h8, 11'h8});
    rck("two_pkt", 8'h0c, 32'hc3ffffff, 32'h00000010);
    rck("two_done", 8'h00, 32'h1, 32'h0);
    conclude();
  end
endmodule : hsitd_top_tb_top
